// ==== core/arc_core.sv ====
// Analog reference characteristic: AHB-Lite registers, two-point mapping engine.
// Assumes samples in hundredths of a percent of full scale, synchronous to the clock.
`timescale 1ns/1ns
module arc_core #(
	parameter logic [15:0] FMIN_RESET = arc_pkg::ARC_FMIN_RESET
) (
	input wire logic CLOCK_IN,
	input wire logic RESET_IN,
	input wire logic CE_IN,
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [2:0] HSIZE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	output logic [31:0] HRDATA_OUT,
	output logic HREADYOUT_OUT,
	output logic HRESP_OUT,
	input wire logic [15:0] ADC_SAMPLE_IN,
	input wire logic ADC_VALID_IN,
	input wire logic DIRECTION_SELECTOR_SWITCH_IN,
	output logic signed [17:0] REF_OUT,
	output logic REF_VALID_OUT,
	output arc_pkg::arc_dest_t REF_DEST_OUT,
	output logic DIGITAL_LEVEL_OUT,
	output logic TERM_DRIVE_OUT
);
	arc_pkg::arc_ctrl_t ctrl;
	logic [15:0] fmin, fmax, pmin, pmax, slip, band;
	logic [3:0] pt_sel;
	logic dp_pending, dp_write;
	logic [7:0] dp_addr;
	arc_pkg::arc_state_t state;
	arc_pkg::arc_coord_t op_x, p1i, p1o, p2i, p2o, yp;
	logic [39:0] quo;
	logic [17:0] rem;
	logic [16:0] dvs;
	logic [5:0] cnt;
	logic q_neg, held_neg;
	arc_pkg::arc_points_t row_a, row_b;

	function automatic logic [15:0] sat_u(input logic [31:0] v, input logic [15:0] lim);
		return (v > {16'h0000, lim}) ? lim : v[15:0];
	endfunction : sat_u

	function automatic arc_pkg::arc_coord_t sat_c(input logic [31:0] v);
		logic signed [31:0] s;
		s = signed'(v);
		if (s > 32'(arc_pkg::ARC_COORD_MAX)) return arc_pkg::ARC_COORD_MAX;
		if (s < 32'(arc_pkg::ARC_COORD_MIN)) return arc_pkg::ARC_COORD_MIN;
		return v[15:0];
	endfunction : sat_c

	// Bus decode: one wait state per transfer
	wire logic accept = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
	wire logic wr_now = dp_pending && dp_write;
	wire logic wr_pt = wr_now && dp_addr == arc_pkg::ARC_OFS_PT_DATA;
	wire logic [15:0] pt_word = (pt_sel[1:0] == 2'h0) ? row_b.point_one_input :
		(pt_sel[1:0] == 2'h1) ? row_b.point_one_output :
		(pt_sel[1:0] == 2'h2) ? row_b.point_two_input : row_b.point_two_output;
	wire logic current_sel = ctrl.mode == arc_pkg::ARC_MODE_CURRENT;
	wire logic [15:0] full_scale = current_sel ? arc_pkg::ARC_FULL_SCALE_UA :
		arc_pkg::ARC_FULL_SCALE_MV;
	wire logic busy = state != arc_pkg::ARC_S_IDLE;
	wire logic [31:0] status_word = {27'h000_0000, DIGITAL_LEVEL_OUT, TERM_DRIVE_OUT,
		current_sel, held_neg, busy};
	wire logic [31:0] rd_mux =
		(dp_addr == arc_pkg::ARC_OFS_CTRL) ? {22'h00_0000, ctrl} :
		(dp_addr == arc_pkg::ARC_OFS_FMIN) ? {16'h0000, fmin} :
		(dp_addr == arc_pkg::ARC_OFS_FMAX) ? {16'h0000, fmax} :
		(dp_addr == arc_pkg::ARC_OFS_PMIN) ? {16'h0000, pmin} :
		(dp_addr == arc_pkg::ARC_OFS_PMAX) ? {16'h0000, pmax} :
		(dp_addr == arc_pkg::ARC_OFS_SLIP) ? {16'h0000, slip} :
		(dp_addr == arc_pkg::ARC_OFS_BAND) ? {16'h0000, band} :
		(dp_addr == arc_pkg::ARC_OFS_PT_SEL) ? {28'h000_0000, pt_sel} :
		(dp_addr == arc_pkg::ARC_OFS_PT_DATA) ? 32'(signed'(pt_word)) :
		(dp_addr == arc_pkg::ARC_OFS_STATUS) ? status_word :
		(dp_addr == arc_pkg::ARC_OFS_RESULT) ? 32'(REF_OUT) :
		(dp_addr == arc_pkg::ARC_OFS_FULLSCALE) ? {16'h0000, full_scale} : 32'h0000_0000;

	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			dp_pending <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
			HREADYOUT_OUT <= 1'b1;
			HRDATA_OUT <= 32'h0000_0000;
			HRESP_OUT <= 1'b0;
		end else if (CE_IN) begin
			dp_pending <= accept;
			HREADYOUT_OUT <= !accept;
			if (accept) begin
				dp_write <= HWRITE_IN;
				dp_addr <= {HADDR_IN[7:2], 2'h0};
			end
			if (dp_pending && !dp_write) begin
				HRDATA_OUT <= rd_mux;
			end
		end
	end

	// Limits saturate at their documented ceilings
	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			ctrl <= arc_pkg::ARC_CTRL_RESET;
			fmin <= FMIN_RESET;
			fmax <= arc_pkg::ARC_FMAX_RESET;
			pmin <= arc_pkg::ARC_PMIN_RESET;
			pmax <= arc_pkg::ARC_PMAX_RESET;
			slip <= arc_pkg::ARC_SLIP_RESET;
			band <= arc_pkg::ARC_BAND_RESET;
			pt_sel <= 4'h0;
		end else if (CE_IN && wr_now) begin
			unique case (dp_addr)
				arc_pkg::ARC_OFS_CTRL: ctrl <= arc_pkg::arc_ctrl_t'(HWDATA_IN[9:0]);
				arc_pkg::ARC_OFS_FMIN: fmin <= sat_u(HWDATA_IN, arc_pkg::ARC_FREQ_LIMIT);
				arc_pkg::ARC_OFS_FMAX: fmax <= sat_u(HWDATA_IN, arc_pkg::ARC_FREQ_LIMIT);
				arc_pkg::ARC_OFS_PMIN: pmin <= sat_u(HWDATA_IN, arc_pkg::ARC_PCT_LIMIT);
				arc_pkg::ARC_OFS_PMAX: pmax <= sat_u(HWDATA_IN, arc_pkg::ARC_PCT_LIMIT);
				arc_pkg::ARC_OFS_SLIP: slip <= HWDATA_IN[15:0];
				arc_pkg::ARC_OFS_BAND: band <= sat_u(HWDATA_IN, arc_pkg::ARC_PCT_FULL);
				arc_pkg::ARC_OFS_PT_SEL: pt_sel <= HWDATA_IN[3:0];
				default: ;
			endcase
		end
	end

	arc_point_mem #(
		.SETS(arc_pkg::ARC_DATA_SETS)
	) u_points (
		.clk_in(CLOCK_IN),
		.rst_in(RESET_IN),
		.ce_in(CE_IN),
		.wr_en_in(wr_pt),
		.wr_set_in(pt_sel[3:2]),
		.wr_coord_in(pt_sel[1:0]),
		.wr_data_in(sat_c(HWDATA_IN)),
		.rd_a_set_in(ctrl.data_set),
		.rd_b_set_in(pt_sel[3:2]),
		.rd_a_out(row_a),
		.rd_b_out(row_b)
	);

	// Operand capture; only analog input modes with the switch off map samples
	wire logic analog_in = ctrl.mode == arc_pkg::ARC_MODE_VOLT_UNI || current_sel ||
		ctrl.mode == arc_pkg::ARC_MODE_VOLT_BI;
	wire logic start = CE_IN && state == arc_pkg::ARC_S_IDLE && ADC_VALID_IN && analog_in &&
		!DIRECTION_SELECTOR_SWITCH_IN;
	wire logic unipolar = ctrl.mode == arc_pkg::ARC_MODE_VOLT_UNI || current_sel;
	wire arc_pkg::arc_coord_t smp = sat_c(32'(signed'(ADC_SAMPLE_IN)));
	wire logic drop1 = unipolar && row_a.point_one_input[15];
	wire logic drop2 = unipolar && row_a.point_two_input[15];

	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			op_x <= 16'h0000;
			p1i <= 16'h0000;
			p1o <= 16'h0000;
			p2i <= 16'h0000;
			p2o <= 16'h0000;
		end else if (start) begin
			op_x <= (unipolar && smp[15]) ? 16'h0000 : smp;
			p1i <= drop1 ? 16'h0000 : row_a.point_one_input;
			p1o <= drop1 ? 16'h0000 : row_a.point_one_output;
			p2i <= drop2 ? 16'h0000 : row_a.point_two_input;
			p2o <= drop2 ? 16'h0000 : row_a.point_two_output;
		end
	end

	// Line terms; band signs need no division, only the sign of the denominator
	wire logic signed [19:0] dy = 20'(p2o) - 20'(p1o);
	wire logic signed [19:0] dx = 20'(op_x) - 20'(p1i);
	wire logic signed [19:0] den = 20'(p2i) - 20'(p1i);
	wire logic signed [19:0] bw = signed'({4'h0, band});
	wire logic signed [19:0] y1w = 20'(p1o);
	wire logic signed [39:0] num = dy * dx;
	wire logic signed [39:0] val_lo = dy * (dx - bw) + y1w * den;
	wire logic signed [39:0] val_hi = dy * (dx + bw) + y1w * den;
	wire logic den_zero = den == 20'sh0_0000;
	wire logic band_pos = val_lo != 0 && val_hi != 0 && val_lo[39] == den[19] &&
		val_hi[39] == den[19];
	wire logic band_neg = val_lo != 0 && val_hi != 0 && val_lo[39] != den[19] &&
		val_hi[39] != den[19];
	wire logic [39:0] num_mag = num[39] ? 40'(-num) : 40'(num);
	wire logic [19:0] den_abs = den[19] ? 20'(-den) : 20'(den);

	// Restoring divider step shared by both passes
	wire logic [17:0] rem_sh = {rem[16:0], quo[39]};
	wire logic fits = rem_sh >= {1'b0, dvs};
	wire logic [17:0] next_rem = fits ? rem_sh - {1'b0, dvs} : rem_sh;
	wire logic [39:0] next_quo = {quo[38:0], fits};
	wire logic div_last = cnt == arc_pkg::ARC_DIV_STEPS - 6'h01;
	// Point-one output is added after the divide, then the sum is clipped to the coordinate range
	wire logic signed [41:0] q_sgn = q_neg ? -signed'({2'b00, next_quo}) :
		signed'({2'b00, next_quo});
	wire logic signed [41:0] y_sum = q_sgn + 42'(p1o);
	wire arc_pkg::arc_coord_t next_yp =
		(y_sum > 42'(arc_pkg::ARC_COORD_MAX)) ? arc_pkg::ARC_COORD_MAX :
		(y_sum < 42'(arc_pkg::ARC_COORD_MIN)) ? arc_pkg::ARC_COORD_MIN : y_sum[15:0];

	// Scaling against limits; the held sign decides the direction
	wire logic yp_agrees = yp == 16'sh0000 || yp[15] == held_neg;
	wire logic [15:0] yp_abs = yp[15] ? 16'(-yp) : 16'(yp);
	wire logic [15:0] mag_pct = yp_agrees ? yp_abs : 16'h0000;
	wire logic [15:0] max_sel = ctrl.freq_cfg ? fmax : pmax;
	wire logic [15:0] min_sel = ctrl.freq_cfg ? fmin : pmin;
	wire logic [16:0] ceil_sel = ctrl.freq_cfg ? 17'(fmax) + 17'(slip) : 17'(pmax);
	wire logic [39:0] scaled = 40'(mag_pct) * 40'(max_sel);
	wire logic [16:0] mag_min = (quo[16:0] < 17'(min_sel)) ? 17'(min_sel) : quo[16:0];
	wire logic [16:0] mag_fin = (mag_min > ceil_sel) ? ceil_sel : mag_min;
	wire logic signed [17:0] next_ref = held_neg ? -signed'({1'b0, mag_fin}) :
		signed'({1'b0, mag_fin});
	wire logic dest_ok = ctrl.dest != arc_pkg::ARC_DEST_ACT_PCT || ctrl.cfg_x11;

	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			state <= arc_pkg::ARC_S_IDLE;
			yp <= 16'h0000;
			held_neg <= 1'b0;
			q_neg <= 1'b0;
		end else if (CE_IN) begin
			unique case (state)
				arc_pkg::ARC_S_IDLE: if (start) begin
					state <= arc_pkg::ARC_S_SETUP;
				end
				arc_pkg::ARC_S_SETUP: begin
					q_neg <= num[39] ^ den[19];
					if (den_zero) begin
						yp <= p1o;
						held_neg <= p1o[15];
						state <= arc_pkg::ARC_S_SCALE;
					end else begin
						if (band_pos) begin
							held_neg <= 1'b0;
						end else if (band_neg) begin
							held_neg <= 1'b1;
						end
						state <= arc_pkg::ARC_S_DIV1;
					end
				end
				arc_pkg::ARC_S_DIV1: if (div_last) begin
					yp <= next_yp;
					state <= arc_pkg::ARC_S_SCALE;
				end
				arc_pkg::ARC_S_SCALE: state <= arc_pkg::ARC_S_DIV2;
				arc_pkg::ARC_S_DIV2: if (div_last) begin
					state <= arc_pkg::ARC_S_DONE;
				end
				arc_pkg::ARC_S_DONE: state <= arc_pkg::ARC_S_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			quo <= 40'h00_0000_0000;
			rem <= 18'h0_0000;
			dvs <= 17'h0_0001;
			cnt <= 6'h00;
		end else if (CE_IN) begin
			if (state == arc_pkg::ARC_S_SETUP || state == arc_pkg::ARC_S_SCALE) begin
				quo <= (state == arc_pkg::ARC_S_SETUP) ? num_mag : scaled;
				dvs <= (state == arc_pkg::ARC_S_SETUP) ? den_abs[16:0] : arc_pkg::ARC_SCALE_DIVISOR;
				rem <= 18'h0_0000;
				cnt <= 6'h00;
			end else if (state == arc_pkg::ARC_S_DIV1 || state == arc_pkg::ARC_S_DIV2) begin
				quo <= next_quo;
				rem <= next_rem;
				cnt <= cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			REF_OUT <= 18'h0_0000;
			REF_VALID_OUT <= 1'b0;
			REF_DEST_OUT <= arc_pkg::ARC_DEST_FREQ;
			DIGITAL_LEVEL_OUT <= 1'b0;
			TERM_DRIVE_OUT <= 1'b0;
		end else if (CE_IN) begin
			REF_VALID_OUT <= state == arc_pkg::ARC_S_DONE && dest_ok;
			if (state == arc_pkg::ARC_S_DONE && dest_ok) begin
				REF_OUT <= next_ref;
				REF_DEST_OUT <= ctrl.dest;
			end
			TERM_DRIVE_OUT <= DIRECTION_SELECTOR_SWITCH_IN;
			if (ADC_VALID_IN && ctrl.mode == arc_pkg::ARC_MODE_DIGITAL &&
				!DIRECTION_SELECTOR_SWITCH_IN) begin
				DIGITAL_LEVEL_OUT <= signed'(ADC_SAMPLE_IN) >= signed'(arc_pkg::ARC_DIGITAL_THRESHOLD);
			end
		end
	end

	// Checks
	wire logic [17:0] ref_mag = REF_OUT[17] ? 18'(-REF_OUT) : 18'(REF_OUT);
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (RESET_IN);

	property p_latency;
		start |-> ##[1:90] (REF_VALID_OUT || !CE_IN || !dest_ok);
	endproperty
	a_latency: assert property (p_latency) else $error("No result after sample");
	property p_unipolar;
		(start && unipolar) |=> (!p1i[15] && !p2i[15] && !op_x[15]);
	endproperty
	a_unipolar: assert property (p_unipolar) else $error("Negative point kept");
	property p_bipolar;
		(start && ctrl.mode == arc_pkg::ARC_MODE_VOLT_BI) |=>
			(p1i == $past(row_a.point_one_input) && p2o == $past(row_a.point_two_output));
	endproperty
	a_bipolar: assert property (p_bipolar) else $error("Bipolar point altered");
	property p_flat;
		(CE_IN && state == arc_pkg::ARC_S_SETUP && den_zero) |=>
			(yp == $past(p1o) && state == arc_pkg::ARC_S_SCALE);
	endproperty
	a_flat: assert property (p_flat) else $error("Equal inputs not flat");
	property p_switch;
		(CE_IN && state == arc_pkg::ARC_S_IDLE && DIRECTION_SELECTOR_SWITCH_IN) |=>
			state == arc_pkg::ARC_S_IDLE;
	endproperty
	a_switch: assert property (p_switch) else $error("Sample taken as output");
	property p_band;
		(CE_IN && state == arc_pkg::ARC_S_SETUP && !den_zero && !band_pos && !band_neg) |=>
			held_neg == $past(held_neg);
	endproperty
	a_band: assert property (p_band) else $error("Sign flipped in band");
	property p_sign;
		REF_VALID_OUT |-> (REF_OUT[17] == held_neg || REF_OUT == 18'sh0_0000);
	endproperty
	a_sign: assert property (p_sign) else $error("Output against held sign");
	property p_min;
		(REF_VALID_OUT && 17'(min_sel) <= ceil_sel) |-> ref_mag >= 18'(min_sel);
	endproperty
	a_min: assert property (p_min) else $error("Output below minimum");
	property p_ceil_f;
		(REF_VALID_OUT && ctrl.freq_cfg) |-> ref_mag <= 18'(ceil_sel);
	endproperty
	a_ceil_f: assert property (p_ceil_f) else $error("Above frequency ceiling");
	property p_ceil_p;
		(REF_VALID_OUT && !ctrl.freq_cfg) |-> ref_mag <= 18'(pmax);
	endproperty
	a_ceil_p: assert property (p_ceil_p) else $error("Above percent ceiling");

	c_negative: cover property (REF_VALID_OUT && REF_OUT[17]);
	c_flat: cover property (state == arc_pkg::ARC_S_SETUP && den_zero);
	c_flip: cover property ($rose(held_neg));
	c_write: cover property (wr_pt);
endmodule : arc_core

// ==== core/arc_point_mem.sv ====
// Characteristic point store: one row of four coordinates per data set.
// Assumes writes and reads in the core clock domain; read data are registered.
`timescale 1ns/1ns
module arc_point_mem #(
	parameter int SETS = arc_pkg::ARC_DATA_SETS
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic wr_en_in,
	input wire logic [$clog2(SETS)-1:0] wr_set_in,
	input wire logic [1:0] wr_coord_in,
	input wire arc_pkg::arc_coord_t wr_data_in,
	input wire logic [$clog2(SETS)-1:0] rd_a_set_in,
	input wire logic [$clog2(SETS)-1:0] rd_b_set_in,
	output arc_pkg::arc_points_t rd_a_out,
	output arc_pkg::arc_points_t rd_b_out
);
	arc_pkg::arc_points_t rows [SETS];
	wire logic [5:0] wr_base = 6'(7'd48 - {wr_coord_in, 4'h0});

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < SETS; i++) begin
				rows[i] <= arc_pkg::ARC_POINTS_RESET;
			end
			rd_a_out <= arc_pkg::ARC_POINTS_RESET;
			rd_b_out <= arc_pkg::ARC_POINTS_RESET;
		end else if (ce_in) begin
			if (wr_en_in) begin
				rows[wr_set_in][wr_base +: 16] <= wr_data_in;
			end
			rd_a_out <= rows[rd_a_set_in];
			rd_b_out <= rows[rd_b_set_in];
		end
	end
endmodule : arc_point_mem

// ==== shared/arc_pkg.sv ====
// Constants, types and register map of the analog reference characteristic.
// Assumes one clock domain; coordinates are signed hundredths of a percent.
// Summary of operation
// - Output follows straight line through two points
// - Input percent of 10 V or 20 mA
// - Coordinates limited to plus/minus 100.00 percent
// - Four point sets, active set used
// - Switch off input, switch on output
// - Voltage or current chosen by mode
// - Bipolar mode uses points unmodified
// - Unipolar mode moves negative points to origin
// - Tolerance band blocks sign reversal near zero
// - Nonzero minimum turns band into hysteresis
// - Held sign kept until band edge crossed
// - Same limits for both rotation directions
// - Frequency limits 0.00 to 599.00 Hz
// - Percentage limits 0.00 to 300.00 percent
// - Frequency ceiling is maximum plus slip
// - Result routed to selectable reference destination
package arc_pkg;
	typedef logic signed [15:0] arc_coord_t;
	typedef struct packed {
		arc_coord_t point_one_input;
		arc_coord_t point_one_output;
		arc_coord_t point_two_input;
		arc_coord_t point_two_output;
	} arc_points_t;
	typedef enum logic [1:0] {
		ARC_DEST_FREQ,
		ARC_DEST_REF_PCT,
		ARC_DEST_ACT_PCT,
		ARC_DEST_LIMIT
	} arc_dest_t;
	typedef struct packed {
		logic [3:0] mode;
		logic [1:0] data_set;
		arc_dest_t dest;
		logic freq_cfg;
		logic cfg_x11;
	} arc_ctrl_t;
	typedef enum logic [2:0] {
		ARC_S_IDLE,
		ARC_S_SETUP,
		ARC_S_DIV1,
		ARC_S_SCALE,
		ARC_S_DIV2,
		ARC_S_DONE
	} arc_state_t;

	localparam int ARC_DATA_SETS = 4;
	localparam logic [3:0] ARC_MODE_VOLT_UNI = 4'h1;
	localparam logic [3:0] ARC_MODE_CURRENT = 4'h2;
	localparam logic [3:0] ARC_MODE_DIGITAL = 4'h3;
	localparam logic [3:0] ARC_MODE_VOLT_BI = 4'h4;
	localparam logic [3:0] ARC_MODE_VOLT_OUT = 4'h5;

	localparam logic [7:0] ARC_OFS_CTRL = 8'h00;
	localparam logic [7:0] ARC_OFS_FMIN = 8'h04;
	localparam logic [7:0] ARC_OFS_FMAX = 8'h08;
	localparam logic [7:0] ARC_OFS_PMIN = 8'h0C;
	localparam logic [7:0] ARC_OFS_PMAX = 8'h10;
	localparam logic [7:0] ARC_OFS_SLIP = 8'h14;
	localparam logic [7:0] ARC_OFS_BAND = 8'h18;
	localparam logic [7:0] ARC_OFS_PT_SEL = 8'h1C;
	localparam logic [7:0] ARC_OFS_PT_DATA = 8'h20;
	localparam logic [7:0] ARC_OFS_STATUS = 8'h24;
	localparam logic [7:0] ARC_OFS_RESULT = 8'h28;
	localparam logic [7:0] ARC_OFS_FULLSCALE = 8'h2C;

	localparam arc_coord_t ARC_COORD_MAX = 16'h2710;
	localparam arc_coord_t ARC_COORD_MIN = 16'hD8F0;
	localparam logic [15:0] ARC_PCT_FULL = 16'h2710;
	localparam logic [15:0] ARC_FREQ_LIMIT = 16'hE9FC;
	localparam logic [15:0] ARC_PCT_LIMIT = 16'h7530;
	localparam logic [15:0] ARC_FULL_SCALE_MV = 16'h2710;
	localparam logic [15:0] ARC_FULL_SCALE_UA = 16'h4E20;
	localparam logic [15:0] ARC_DIGITAL_THRESHOLD = 16'h1388;
	localparam logic [16:0] ARC_SCALE_DIVISOR = 17'h0_2710;
	localparam logic [5:0] ARC_DIV_STEPS = 6'h28;

	localparam arc_ctrl_t ARC_CTRL_RESET = '{mode: ARC_MODE_VOLT_UNI, data_set: 2'h0,
		dest: ARC_DEST_FREQ, freq_cfg: 1'b1, cfg_x11: 1'b0};
	localparam logic [15:0] ARC_FMIN_RESET = 16'h015E;
	localparam logic [15:0] ARC_FMAX_RESET = 16'h1388;
	localparam logic [15:0] ARC_PMIN_RESET = 16'h0000;
	localparam logic [15:0] ARC_PMAX_RESET = 16'h2710;
	localparam logic [15:0] ARC_SLIP_RESET = 16'h0000;
	localparam logic [15:0] ARC_BAND_RESET = 16'h00C8;
	localparam arc_points_t ARC_POINTS_RESET = {16'hD9B8, 16'hD8F0, 16'h2648, 16'h2710};
endpackage : arc_pkg

// ==== tb/arc_adc_model.sv ====
// Converter model: offers one sample per request, promptly or three cycles late.
// Assumes requests one cycle wide; reset asynchronous, active high.
`timescale 1ns/1ns
module arc_adc_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic go_in,
	input wire logic slow_in,
	input wire logic [15:0] value_in,
	output logic [15:0] sample_out,
	output logic valid_out
);
	logic [1:0] wait_cnt;
	logic pending;
	logic [15:0] held;
	// Between samples the data lines toggle so nothing stale looks valid
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pending <= 1'b0;
			wait_cnt <= 2'h0;
			held <= 16'h0000;
			sample_out <= 16'hA5A5;
			valid_out <= 1'b0;
		end else if (go_in) begin
			pending <= 1'b1;
			wait_cnt <= slow_in ? 2'h3 : 2'h0;
			held <= value_in;
			sample_out <= ~sample_out;
			valid_out <= 1'b0;
		end else if (pending && wait_cnt == 2'h0) begin
			pending <= 1'b0;
			sample_out <= held;
			valid_out <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt - {1'b0, pending};
			sample_out <= ~sample_out;
			valid_out <= 1'b0;
		end
	end
endmodule : arc_adc_model

// ==== tb/test_analog_reference_characteristic.sv ====
// Self-checking bench: AHB-Lite register tasks, converter model, mapping scenarios.
// Assumes one clock at 10 MHz; expected values worked out by hand from the line.
`timescale 1ns/1ns
module test_analog_reference_characteristic;
	logic clock_in, reset_in, hsel, hwrite, go, slow_ans, switch_in, adc_valid;
	logic hreadyout, ref_valid, dig_level, term_drive, hresp, ce;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [15:0] value, adc_sample;
	logic signed [17:0] ref_out;
	arc_pkg::arc_dest_t ref_dest;
	int failures, n_checks;
	arc_adc_model adc (.clk_in(clock_in), .rst_in(reset_in), .go_in(go), .slow_in(slow_ans),
		.value_in(value), .sample_out(adc_sample), .valid_out(adc_valid));
	arc_core DUT (.CLOCK_IN(clock_in), .RESET_IN(reset_in), .CE_IN(ce), .HSEL_IN(hsel),
		.HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
		.HWDATA_IN(hwdata), .HREADY_IN(hreadyout), .HRDATA_OUT(hrdata),
		.HREADYOUT_OUT(hreadyout), .HRESP_OUT(hresp), .ADC_SAMPLE_IN(adc_sample),
		.ADC_VALID_IN(adc_valid), .DIRECTION_SELECTOR_SWITCH_IN(switch_in),
		.REF_OUT(ref_out), .REF_VALID_OUT(ref_valid), .REF_DEST_OUT(ref_dest),
		.DIGITAL_LEVEL_OUT(dig_level), .TERM_DRIVE_OUT(term_drive));
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : test_done
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check_val
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge clock_in);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			test_done;
		end
	endtask : wait_ready
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h00_0000, a};
		wait_ready;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready;
		rd = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0000_0000, x);
		check_val(x, exp);
	endtask : rd_chk
	task automatic set_points(input logic [1:0] s, input arc_pkg::arc_points_t p);
		for (int k = 0; k < 4; k++) begin
			wr(arc_pkg::ARC_OFS_PT_SEL, {28'h000_0000, s, k[1:0]});
			wr(arc_pkg::ARC_OFS_PT_DATA, {{16{p[63-16*k]}}, p[63-16*k -: 16]});
		end
	endtask : set_points
	task automatic sample(input logic [15:0] x, input logic slow, input logic pulse,
		input logic [31:0] expv);
		int n;
		n = 0;
		go <= 1'b1;
		value <= x;
		slow_ans <= slow;
		@(posedge clock_in);
		go <= 1'b0;
		do begin
			@(posedge clock_in);
			n++;
		end while (ref_valid !== 1'b1 && n < 150);
		check_val({31'h0, ref_valid}, {31'h0, pulse});
		if (pulse) check_val({{14{ref_out[17]}}, ref_out}, expv);
	endtask : sample
	task automatic t_reset;
		rd_chk(arc_pkg::ARC_OFS_CTRL, 32'h0000_0042);
		rd_chk(arc_pkg::ARC_OFS_FMIN, 32'h0000_015E);
		rd_chk(arc_pkg::ARC_OFS_FMAX, 32'h0000_1388);
		rd_chk(arc_pkg::ARC_OFS_PMAX, 32'h0000_2710);
		rd_chk(arc_pkg::ARC_OFS_PT_DATA, 32'hFFFF_D9B8);
		rd_chk(8'h3C, 32'h0000_0000);
		check_val({31'h0, hresp}, 32'h0000_0000);
		wr(arc_pkg::ARC_OFS_FMAX, 32'h0000_EA60);
		rd_chk(arc_pkg::ARC_OFS_FMAX, 32'h0000_E9FC);
		wr(arc_pkg::ARC_OFS_FMAX, 32'h0000_1388);
		wr(arc_pkg::ARC_OFS_PMAX, 32'h0000_9C40);
		rd_chk(arc_pkg::ARC_OFS_PMAX, 32'h0000_7530);
		wr(arc_pkg::ARC_OFS_PT_SEL, 32'h0000_000C);
		wr(arc_pkg::ARC_OFS_PT_DATA, 32'h0000_2EE0);
		rd_chk(arc_pkg::ARC_OFS_PT_DATA, 32'h0000_2710);
		$display("reset test done");
	endtask : t_reset
	task automatic t_lines;
		wr(arc_pkg::ARC_OFS_FMIN, 32'h0000_0000);
		set_points(2'h1, {16'hD8F0, 16'hD8F0, 16'h2710, 16'h2710});
		set_points(2'h2, {16'hE4A8, 16'hEC78, 16'h1F40, 16'h2134});
		set_points(2'h3, {16'h1388, 16'h0BB8, 16'h1388, 16'h0BB8});
		wr(arc_pkg::ARC_OFS_CTRL, 32'h0000_0122);
		sample(16'h1F40, 1'b0, 1'b1, 32'h0000_109A);
		sample(16'hE4A8, 1'b1, 1'b1, 32'hFFFF_F63C);
		wr(arc_pkg::ARC_OFS_CTRL, 32'h0000_0062);
		sample(16'h0FA0, 1'b0, 1'b1, 32'h0000_084D);
		rd_chk(arc_pkg::ARC_OFS_FULLSCALE, 32'h0000_2710);
		wr(arc_pkg::ARC_OFS_CTRL, 32'h0000_0132);
		sample(16'h0000, 1'b0, 1'b1, 32'h0000_05DC);
		$display("line test done");
	endtask : t_lines
	task automatic t_hyst;
		wr(arc_pkg::ARC_OFS_FMIN, 32'h0000_015E);
		wr(arc_pkg::ARC_OFS_CTRL, 32'h0000_0112);
		sample(16'h1388, 1'b0, 1'b1, 32'h0000_09C4);
		sample(16'hFF9C, 1'b0, 1'b1, 32'h0000_015E);
		sample(16'hFED4, 1'b1, 1'b1, 32'hFFFF_FEA2);
		sample(16'h0064, 1'b0, 1'b1, 32'hFFFF_FEA2);
		rd_chk(arc_pkg::ARC_OFS_STATUS, 32'h0000_0002);
		rd_chk(arc_pkg::ARC_OFS_RESULT, 32'hFFFF_FEA2);
		wr(arc_pkg::ARC_OFS_FMIN, 32'h0000_1770);
		wr(arc_pkg::ARC_OFS_SLIP, 32'h0000_01F4);
		sample(16'h1388, 1'b0, 1'b1, 32'h0000_157C);
		$display("hysteresis test done");
	endtask : t_hyst
	task automatic t_dest;
		wr(arc_pkg::ARC_OFS_PMAX, 32'h0000_4E20);
		for (int d = 0; d < 4; d++) begin
			wr(arc_pkg::ARC_OFS_CTRL, 32'h0000_0110 + 32'(d * 4 + (d == 2)));
			sample(16'h1388, 1'b0, 1'b1, 32'h0000_2710);
			check_val({30'h0, ref_dest}, d);
		end
		wr(arc_pkg::ARC_OFS_CTRL, 32'h0000_0118);
		sample(16'h1388, 1'b0, 1'b0, 32'h0000_0000);
		$display("destination test done");
	endtask : t_dest
	task automatic t_terminal;
		wr(arc_pkg::ARC_OFS_CTRL, 32'h0000_0082);
		rd_chk(arc_pkg::ARC_OFS_FULLSCALE, 32'h0000_4E20);
		wr(arc_pkg::ARC_OFS_CTRL, 32'h0000_00C2);
		sample(16'h1770, 1'b0, 1'b0, 32'h0000_0000);
		check_val({31'h0, dig_level}, 32'h0000_0001);
		wr(arc_pkg::ARC_OFS_CTRL, 32'h0000_0112);
		switch_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		check_val({31'h0, term_drive}, 32'h0000_0001);
		sample(16'h1388, 1'b0, 1'b0, 32'h0000_0000);
		switch_in <= 1'b0;
		// A sample offered while the block is frozen is lost
		ce <= 1'b0;
		sample(16'h1388, 1'b0, 1'b0, 32'h0000_0000);
		ce <= 1'b1;
		sample(16'h1388, 1'b0, 1'b1, 32'h0000_157C);
		$display("terminal test done");
	endtask : t_terminal
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end
	initial begin
		#5000000;
		failures++;
		test_done;
	end
	initial begin
		{hsel, hwrite, go, slow_ans, switch_in} = 5'h00;
		ce = 1'b1;
		htrans = 2'h0;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		value = 16'h0000;
		failures = 0;
		n_checks = 0;
		reset_in = 1'b1;
		repeat (12) @(posedge clock_in);
		reset_in <= 1'b0;
		t_reset;
		t_lines;
		t_hyst;
		t_dest;
		t_terminal;
		test_done;
	end
endmodule : test_analog_reference_characteristic
